// ### include/cpm_pkg.sv
// Package of constants and types for the clock prescaler and power mode controller.
package cpm_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the APB bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SYS_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_SYS_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_MOD_HALT_ONE = 8'h08;
  localparam logic [7:0] ADDR_MOD_HALT_TWO = 8'h0C;
  localparam logic [7:0] ADDR_MODE_STATUS = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int STANDBY_SELECT_BIT = 7;
  localparam int WAKE_WAIT_SEL_LSB = 4;
  localparam int SUBSLEEP_SELECT_BIT = 3;
  localparam logic [7:0] SYS_CTRL_ONE_WMASK = 8'hF0;
  localparam logic [7:0] SYS_CTRL_TWO_WMASK = 8'h0F;
  localparam logic [7:0] SYS_CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] SYS_CTRL_TWO_RESET = 8'h00;
  localparam logic [7:0] MOD_HALT_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Prescaler and system clock divider
  // ----------------------------------------------------------------
  localparam int PRESCALER_WIDTH = 13;
  localparam logic [2:0] DIV_BY_1 = 3'h0;
  localparam logic [2:0] DIV_BY_8 = 3'h4;
  localparam logic [2:0] DIV_BY_16 = 3'h5;
  localparam logic [2:0] DIV_BY_32 = 3'h6;
  localparam logic [2:0] DIV_BY_64 = 3'h7;
  localparam logic [5:0] LIMIT_DIV_1 = 6'h00;
  localparam logic [5:0] LIMIT_DIV_8 = 6'h07;
  localparam logic [5:0] LIMIT_DIV_16 = 6'h0F;
  localparam logic [5:0] LIMIT_DIV_32 = 6'h1F;
  localparam logic [5:0] LIMIT_DIV_64 = 6'h3F;

  // ----------------------------------------------------------------
  // Wake settling wait, counted in oscillator clocks
  // ----------------------------------------------------------------
  localparam int WAKE_WAIT_WIDTH = 20;
  localparam logic [2:0] WAKE_WAIT_SEL_MIN = 3'h7;
  localparam logic [19:0] WAKE_WAIT_MIN_CYCLES = 20'h00010;

  // Operating modes of the controller.
  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'b000,
    MODE_SLEEP = 3'b001,
    MODE_STANDBY = 3'b010,
    MODE_SUBSLEEP = 3'b011,
    MODE_WAKE_WAIT = 3'b100
  } cpm_mode_t;

endpackage : cpm_pkg

// ### rtl/cpm_clk_div.sv
// System clock divider: turns the oscillator clock into a system clock tick.
module cpm_clk_div (
  input wire logic pclk, // Oscillator clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic run, // High while the system clock generator runs.
  input wire logic [2:0] div_sel, // Active clock divide code.
  output logic tick // One pulse per system clock period.
);

  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic tick_reg;
  logic tick_next;
  logic [5:0] limit;

  // Decodes the divide code into the last count of one period.
  always_comb begin
    case (div_sel)
      cpm_pkg::DIV_BY_8: limit = cpm_pkg::LIMIT_DIV_8;
      cpm_pkg::DIV_BY_16: limit = cpm_pkg::LIMIT_DIV_16;
      cpm_pkg::DIV_BY_32: limit = cpm_pkg::LIMIT_DIV_32;
      cpm_pkg::DIV_BY_64: limit = cpm_pkg::LIMIT_DIV_64;
      default: limit = cpm_pkg::LIMIT_DIV_1;
    endcase
  end

  // Counts oscillator clocks and marks the end of each system clock period.
  always_comb begin
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (!run) begin
      cnt_next = 6'h00;
    end else if (cnt_reg >= limit) begin
      cnt_next = 6'h00;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 6'h01;
    end
  end

  // Registers the divider state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 6'h00;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule : cpm_clk_div

// ### rtl/cpm_prescaler.sv
// Free-running prescaler that supplies the divided clock taps.
module cpm_prescaler (
  input wire logic pclk, // Oscillator clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic advance, // System clock tick.
  input wire logic clear, // Holds the count at zero.
  output logic [12:0] count // Prescaler count, bit i toggles at tick rate over 2 to the i.
);

  logic [12:0] cnt_reg;
  logic [12:0] cnt_next;

  // Advances once per system clock period unless held cleared.
  always_comb begin
    cnt_next = cnt_reg;
    if (clear) begin
      cnt_next = 13'h0000;
    end else if (advance) begin
      cnt_next = cnt_reg + 13'h0001;
    end
  end

  // Registers the count; reset clears it and counting starts on release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 13'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign count = cnt_reg;

endmodule : cpm_prescaler

// ### rtl/cpm_power_ctrl.sv
// Top of the clock prescaler and power mode controller with its APB register slave.
//
// How it works
// - The prescaler is a 13-bit counter that advances once per system clock period.
// - Reset clears the prescaler to zero and it counts as soon as reset is released.
// - In standby and subsleep the system clock stops and the prescaler is held at zero.
// - Software has no register path to read or write the prescaler count.
// - Taps from the system clock over 2 to over 8192 are offered to every peripheral.
// - In active and sleep the prescaler clock is the oscillator divided by the divide field.
// - The system clock is the oscillator undivided or divided by 8, 16, 32 or 64.
// - In sleep the processor halts while peripherals keep running on the system clock.
// - In standby and subsleep everything halts, and subsleep also holds the I/O ports.
// - Each peripheral can be halted on its own, whatever the current mode.
// - A sleep request enters sleep when standby select is 0; when it is 1, subsleep if subsleep select is 1 and standby if it is 0.
// - A wake from standby holds processor and peripherals for the selected settling wait.
// - The four low bits of the first control register read as zero and ignore writes.
//
// Added by the designer: the register offsets and the APB interface to the registers.
module cpm_power_ctrl #(
  parameter int WAKE_WAIT_BASE = 8192 // Oscillator clocks of the longest-but-six wait step.
) (
  input wire logic pclk, // Oscillator clock, 100 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for an unmapped address.
  input wire logic sleep_req, // Pulse: the processor executed the sleep instruction.
  input wire logic wake_irq, // Level: an interrupt asks to leave a low power mode.
  output logic cpu_run, // High while the processor may run.
  output logic periph_run, // High while peripherals may run.
  output logic port_hold, // High while I/O ports hold their state.
  output logic sys_tick, // One pulse per system clock period.
  output logic [12:0] clk_taps, // Prescaler taps, bit i is system clock over 2 to the i+1.
  output logic [15:0] module_run, // Per peripheral run enable.
  output logic [2:0] mode // Current operating mode code.
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] sys_ctrl_one_reg;
  logic [7:0] sys_ctrl_one_next;
  logic [7:0] sys_ctrl_two_reg;
  logic [7:0] sys_ctrl_two_next;
  logic [15:0] mod_halt_reg;
  logic [15:0] mod_halt_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  cpm_pkg::cpm_mode_t mode_reg;
  cpm_pkg::cpm_mode_t mode_next;
  logic [19:0] wait_reg;
  logic [19:0] wait_next;
  logic cpu_run_reg;
  logic cpu_run_next;
  logic periph_run_reg;
  logic periph_run_next;
  logic port_hold_reg;
  logic port_hold_next;
  logic [15:0] module_run_reg;
  logic [15:0] module_run_next;
  logic setup_phase;
  logic access_done;
  logic addr_hit;
  logic [7:0] read_byte;
  logic clk_gen_run;
  logic tick_w;
  logic [12:0] count_w;
  logic [2:0] wake_sel;
  logic [19:0] wake_load;
  logic standby_select;
  logic subsleep_select;

  // ----------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------
  // Splits the control registers into their fields.
  assign standby_select = sys_ctrl_one_reg[cpm_pkg::STANDBY_SELECT_BIT];
  assign wake_sel = sys_ctrl_one_reg[cpm_pkg::WAKE_WAIT_SEL_LSB +: 3];
  assign subsleep_select = sys_ctrl_two_reg[cpm_pkg::SUBSLEEP_SELECT_BIT];

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Qualifies the two phases of a transfer.
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready_reg;

  // Decodes the address and selects the byte returned on a read.
  always_comb begin
    addr_hit = 1'b1;
    read_byte = 8'h00;
    case (paddr)
      cpm_pkg::ADDR_SYS_CTRL_ONE: read_byte = sys_ctrl_one_reg & cpm_pkg::SYS_CTRL_ONE_WMASK;
      cpm_pkg::ADDR_SYS_CTRL_TWO: read_byte = sys_ctrl_two_reg;
      cpm_pkg::ADDR_MOD_HALT_ONE: read_byte = mod_halt_reg[7:0];
      cpm_pkg::ADDR_MOD_HALT_TWO: read_byte = mod_halt_reg[15:8];
      cpm_pkg::ADDR_MODE_STATUS: read_byte = {5'h00, mode_reg};
      default: addr_hit = 1'b0;
    endcase
  end

  // Answers every transfer in its first access cycle with registered data.
  always_comb begin
    pready_next = setup_phase;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    if (setup_phase) begin
      prdata_next = pwrite ? 32'h00000000 : {24'h000000, read_byte};
      pslverr_next = !addr_hit;
    end else if (access_done) begin
      prdata_next = 32'h00000000;
    end
  end

  // Applies a write at the edge that completes the access phase.
  always_comb begin
    sys_ctrl_one_next = sys_ctrl_one_reg;
    sys_ctrl_two_next = sys_ctrl_two_reg;
    mod_halt_next = mod_halt_reg;
    if (access_done && pwrite) begin
      case (paddr)
        cpm_pkg::ADDR_SYS_CTRL_ONE: begin
          sys_ctrl_one_next = pwdata[7:0] & cpm_pkg::SYS_CTRL_ONE_WMASK;
        end
        cpm_pkg::ADDR_SYS_CTRL_TWO: begin
          sys_ctrl_two_next = pwdata[7:0] & cpm_pkg::SYS_CTRL_TWO_WMASK;
        end
        cpm_pkg::ADDR_MOD_HALT_ONE: begin
          mod_halt_next[7:0] = pwdata[7:0];
        end
        cpm_pkg::ADDR_MOD_HALT_TWO: begin
          mod_halt_next[15:8] = pwdata[7:0];
        end
        default: begin
          mod_halt_next = mod_halt_reg;
        end
      endcase
    end
  end

  // Registers the bus answer and the control registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      sys_ctrl_one_reg <= cpm_pkg::SYS_CTRL_ONE_RESET;
      sys_ctrl_two_reg <= cpm_pkg::SYS_CTRL_TWO_RESET;
      mod_halt_reg <= {cpm_pkg::MOD_HALT_RESET, cpm_pkg::MOD_HALT_RESET};
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      sys_ctrl_one_reg <= sys_ctrl_one_next;
      sys_ctrl_two_reg <= sys_ctrl_two_next;
      mod_halt_reg <= mod_halt_next;
    end
  end

  // ----------------------------------------------------------------
  // Mode control
  // ----------------------------------------------------------------
  // Length of the settling wait for the selected wake wait code.
  always_comb begin
    if (wake_sel == cpm_pkg::WAKE_WAIT_SEL_MIN) begin
      wake_load = cpm_pkg::WAKE_WAIT_MIN_CYCLES;
    end else begin
      wake_load = 20'(WAKE_WAIT_BASE << wake_sel);
    end
  end

  // Steps through the operating modes on sleep requests and wake interrupts.
  always_comb begin
    mode_next = mode_reg;
    wait_next = wait_reg;
    case (mode_reg)
      cpm_pkg::MODE_ACTIVE: begin
        if (sleep_req) begin
          if (!standby_select) begin
            mode_next = cpm_pkg::MODE_SLEEP;
          end else if (subsleep_select) begin
            mode_next = cpm_pkg::MODE_SUBSLEEP;
          end else begin
            mode_next = cpm_pkg::MODE_STANDBY;
          end
        end
      end
      cpm_pkg::MODE_SLEEP: begin
        if (wake_irq) begin
          mode_next = cpm_pkg::MODE_ACTIVE;
        end
      end
      cpm_pkg::MODE_STANDBY: begin
        if (wake_irq) begin
          mode_next = cpm_pkg::MODE_WAKE_WAIT;
          wait_next = wake_load - 20'h00001;
        end
      end
      cpm_pkg::MODE_SUBSLEEP: begin
        if (wake_irq) begin
          mode_next = cpm_pkg::MODE_ACTIVE;
        end
      end
      cpm_pkg::MODE_WAKE_WAIT: begin
        if (wait_reg == 20'h00000) begin
          mode_next = cpm_pkg::MODE_ACTIVE;
        end else begin
          wait_next = wait_reg - 20'h00001;
        end
      end
      default: begin
        mode_next = cpm_pkg::MODE_ACTIVE;
        wait_next = 20'h00000;
      end
    endcase
  end

  // Derives the run and hold enables from the next mode.
  always_comb begin
    cpu_run_next = 1'b0;
    periph_run_next = 1'b0;
    port_hold_next = 1'b0;
    case (mode_next)
      cpm_pkg::MODE_ACTIVE: begin
        cpu_run_next = 1'b1;
        periph_run_next = 1'b1;
      end
      cpm_pkg::MODE_SLEEP: begin
        periph_run_next = 1'b1;
      end
      cpm_pkg::MODE_SUBSLEEP: begin
        port_hold_next = 1'b1;
      end
      default: begin
        cpu_run_next = 1'b0;
      end
    endcase
    module_run_next = {16{periph_run_next}} & ~mod_halt_next;
  end

  // Registers the mode state and the enables it drives.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= cpm_pkg::MODE_ACTIVE;
      wait_reg <= 20'h00000;
      cpu_run_reg <= 1'b1;
      periph_run_reg <= 1'b1;
      port_hold_reg <= 1'b0;
      module_run_reg <= 16'hFFFF;
    end else begin
      mode_reg <= mode_next;
      wait_reg <= wait_next;
      cpu_run_reg <= cpu_run_next;
      periph_run_reg <= periph_run_next;
      port_hold_reg <= port_hold_next;
      module_run_reg <= module_run_next;
    end
  end

  // ----------------------------------------------------------------
  // Clock generation
  // ----------------------------------------------------------------
  // The system clock generator runs only in active and sleep. It follows the mode being
  // entered, so the divider and prescaler are already clear in the first stopped cycle.
  assign clk_gen_run = (mode_next == cpm_pkg::MODE_ACTIVE)
    || (mode_next == cpm_pkg::MODE_SLEEP);

  // Divides the oscillator clock by the active clock divide field.
  cpm_clk_div u_clk_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(clk_gen_run),
    .div_sel(sys_ctrl_two_reg[2:0]),
    .tick(tick_w)
  );

  // Counts system clock periods into the shared taps.
  cpm_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .advance(tick_w),
    .clear(!clk_gen_run),
    .count(count_w)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output comes from a register.
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign cpu_run = cpu_run_reg;
  assign periph_run = periph_run_reg;
  assign port_hold = port_hold_reg;
  assign module_run = module_run_reg;
  assign mode = mode_reg;
  assign sys_tick = tick_w;
  assign clk_taps = count_w;

endmodule : cpm_power_ctrl

// ### verif/cpm_power_ctrl_chk.sv
// Concurrent checks on the ports of the power mode controller.
module cpm_power_ctrl_chk #(
  parameter int WAKE_WAIT_BASE = 8192 // Oscillator clocks of the wait base step.
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [31:0] prdata, // APB read data.
  input wire logic pready, // APB ready.
  input wire logic pslverr, // APB error.
  input wire logic sleep_req, // Sleep instruction pulse.
  input wire logic wake_irq, // Wake interrupt.
  input wire logic cpu_run, // Processor enable.
  input wire logic periph_run, // Peripheral enable.
  input wire logic port_hold, // Port hold.
  input wire logic sys_tick, // System clock tick.
  input wire logic [12:0] clk_taps, // Prescaler taps.
  input wire logic [15:0] module_run, // Per module enables.
  input wire logic [2:0] mode // Mode code.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_ok;
  logic standby_select_reg, standby_select_next, sub_reg, sub_next;
  logic [2:0] sel_reg, sel_next;
  logic [19:0] wait_reg, wait_next, exp_wait;

  // Shadows the control fields and counts cycles spent in the wake wait.
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  always_comb begin
    standby_select_next = (wr_ok && paddr == 8'h00) ? pwdata[7] : standby_select_reg;
    sel_next = (wr_ok && paddr == 8'h00) ? pwdata[6:4] : sel_reg;
    sub_next = (wr_ok && paddr == 8'h04) ? pwdata[3] : sub_reg;
    wait_next = (mode == 3'h4) ? wait_reg + 20'h00001 : 20'h00000;
    exp_wait = (sel_reg == 3'h7) ? 20'h00010 : 20'(WAKE_WAIT_BASE << sel_reg);
  end

  // Registers the shadows.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_select_reg <= 1'b0;
      sel_reg <= 3'h0;
      sub_reg <= 1'b0;
      wait_reg <= 20'h00000;
    end else begin
      standby_select_reg <= standby_select_next;
      sel_reg <= sel_next;
      sub_reg <= sub_next;
      wait_reg <= wait_next;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wake_req;
    mode == 3'h2 && wake_irq;
  endsequence
  sequence s_wait_done;
    mode == 3'h4 ##1 mode != 3'h4;
  endsequence

  property p_reserved_zero;
    pready && !pwrite && paddr == 8'h00 |-> prdata == {24'h0, standby_select_reg, sel_reg, 4'h0};
  endproperty
  property p_sleep_entry;
    mode == 3'h0 && sleep_req |=>
      mode == (!$past(standby_select_reg) ? 3'h1 : ($past(sub_reg) ? 3'h3 : 3'h2));
  endproperty
  property p_halt_taps;
    mode == 3'h2 || mode == 3'h3 |-> clk_taps == 13'h0000 && !sys_tick;
  endproperty
  property p_sleep_run;
    mode == 3'h1 |-> !cpu_run && periph_run;
  endproperty
  property p_sub_hold;
    mode == 3'h3 |-> port_hold && !cpu_run && !periph_run;
  endproperty
  property p_mod_halt;
    !periph_run |-> module_run == 16'h0000;
  endproperty
  property p_count_step;
    clk_taps != $past(clk_taps) && clk_taps != 13'h0000 |->
      clk_taps == $past(clk_taps) + 13'h0001;
  endproperty
  property p_wake_enter;
    s_wake_req |=> mode == 3'h4 && !cpu_run && !periph_run;
  endproperty
  property p_wake_len;
    s_wait_done |-> mode == 3'h0 && cpu_run && wait_reg == exp_wait;
  endproperty
  property p_wake_bound;
    mode == 3'h4 |-> wait_reg < exp_wait;
  endproperty

  a_reserved_zero: assert property (p_reserved_zero) else $error("control one readback wrong");
  a_sleep_entry: assert property (p_sleep_entry) else $error("wrong mode after sleep");
  a_halt_taps: assert property (p_halt_taps) else $error("prescaler runs in stop");
  a_sleep_run: assert property (p_sleep_run) else $error("sleep enables wrong");
  a_sub_hold: assert property (p_sub_hold) else $error("subsleep enables wrong");
  a_mod_halt: assert property (p_mod_halt) else $error("module runs while halted");
  a_count_step: assert property (p_count_step) else $error("prescaler step wrong");
  a_wake_enter: assert property (p_wake_enter) else $error("no wake wait");
  a_wake_len: assert property (p_wake_len) else $error("wake wait length wrong");
  a_wake_bound: assert property (p_wake_bound) else $error("wake wait too long");
endmodule : cpm_power_ctrl_chk

bind cpm_power_ctrl cpm_power_ctrl_chk #(.WAKE_WAIT_BASE(WAKE_WAIT_BASE)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sleep_req(sleep_req), .wake_irq(wake_irq), .cpu_run(cpu_run), .periph_run(periph_run),
  .port_hold(port_hold), .sys_tick(sys_tick), .clk_taps(clk_taps),
  .module_run(module_run), .mode(mode)
);

// ### verif/cpm_cpu_model.sv
// Behavioural model of the processor side: sleep instruction and wake interrupt.
module cpm_cpu_model (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic go_sleep, // Bench asks for the sleep instruction.
  input wire logic go_wake, // Bench asks for a wake interrupt.
  input wire logic cpu_run, // Processor may run.
  output logic sleep_req, // One-cycle sleep instruction pulse.
  output logic wake_irq // Interrupt level, held until the processor runs.
);
  timeunit 1ns;
  timeprecision 1ps;

  // Only a running processor executes sleep; the interrupt stays up until serviced.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_req <= 1'b0;
      wake_irq <= 1'b0;
    end else begin
      sleep_req <= go_sleep && cpu_run;
      wake_irq <= go_wake || (wake_irq && !cpu_run);
    end
  end
endmodule : cpm_cpu_model

// ### verif/cpm_power_ctrl_tb.sv
// Self-checking testbench of the clock prescaler and power mode controller.
module cpm_power_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WBASE = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go_sleep = 1'b0, go_wake = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, sleep_req, wake_irq, cpu_run, periph_run, port_hold, sys_tick;
  logic [12:0] clk_taps, t0, dt;
  logic [15:0] module_run;
  logic [2:0] mode;
  logic [2:0] div_code [5] = '{3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  int div_per [5] = '{1, 8, 16, 32, 64};
  int bad_count = 0, compares = 0, n, per;

  // Clock at 100 MHz.
  always #5 pclk = ~pclk;

  cpm_power_ctrl #(.WAKE_WAIT_BASE(WBASE)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
    .wake_irq(wake_irq), .cpu_run(cpu_run), .periph_run(periph_run), .port_hold(port_hold),
    .sys_tick(sys_tick), .clk_taps(clk_taps), .module_run(module_run), .mode(mode));
  cpm_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .go_sleep(go_sleep),
    .go_wake(go_wake), .cpu_run(cpu_run), .sleep_req(sleep_req), .wake_irq(wake_irq));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; waits for pready with a bound, then idles one cycle.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      end_sim();
    end
    @(posedge pclk);
  endtask : apb

  task automatic wait_mode(input logic [2:0] m);
    n = 0;
    while (mode !== m && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (mode !== m) begin
      bad_count++;
      end_sim();
    end
  endtask : wait_mode

  task automatic wait_tick;
    per = 0;
    do begin
      @(posedge pclk);
      per++;
    end while (sys_tick !== 1'b1 && per < 200);
    if (sys_tick !== 1'b1) begin
      bad_count++;
      end_sim();
    end
  endtask : wait_tick

  // Pulses the sleep request when s is high, the wake request otherwise.
  task automatic pulse(input logic s);
    if (s) begin
      go_sleep <= 1'b1;
    end else begin
      go_wake <= 1'b1;
    end
    @(posedge pclk);
    go_sleep <= 1'b0;
    go_wake <= 1'b0;
  endtask : pulse

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    chk("reset_taps", {19'h0, clk_taps}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset_reg", rdat, 32'h0);
    end
    chk("reset_run", {29'h0, cpu_run, periph_run, port_hold}, 32'h6);
    chk("taps_start", {31'h0, clk_taps != 13'h0}, 32'h1);
    apb(1'b1, 8'h00, 32'hFF);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl_one", rdat, 32'hF0);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped_err", {31'h0, rerr}, 32'h1);
    chk("unmapped_data", rdat, 32'h0);
    apb(1'b1, 8'h08, 32'h5A);
    apb(1'b1, 8'h0C, 32'hC3);
    chk("module_run", {16'h0, module_run}, 32'h3CA5);
    // Divide codes 3 to 7: tick spacing and eight tap steps per eight ticks.
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 8'h04, {29'h0, div_code[i]});
      wait_tick();
      wait_tick();
      wait_tick();
      chk("tick_period", 32'(per), 32'(div_per[i]));
      t0 = clk_taps;
      repeat (8 * div_per[i]) @(posedge pclk);
      dt = clk_taps - t0;
      chk("tap_advance", {19'h0, dt}, 32'h8);
    end
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h00, 32'h0);
    pulse(1'b1);
    wait_mode(3'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk("mode_status", rdat, 32'h1);
    wait_tick();
    chk("sleep_run", {15'h0, cpu_run, module_run}, 32'h3CA5);
    chk("sleep_tick", 32'(per), 32'h1);
    pulse(1'b0);
    wait_mode(3'h0);
    // Standby with every wake wait selection.
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, 8'h00, 32'h80 | (s << 4));
      pulse(1'b1);
      wait_mode(3'h2);
      repeat (3) @(posedge pclk);
      chk("standby_taps", {19'h0, clk_taps}, 32'h0);
      chk("standby_run", {14'h0, cpu_run, periph_run, module_run}, 32'h0);
      pulse(1'b0);
      wait_mode(3'h4);
      per = 0;
      while (mode !== 3'h0 && per < 1000) begin
        @(posedge pclk);
        per++;
      end
      chk("wake_wait", 32'(per), (s == 7) ? 32'h10 : 32'(WBASE << s));
    end
    apb(1'b1, 8'h04, 32'h8);
    pulse(1'b1);
    wait_mode(3'h3);
    chk("subsleep", {29'h0, port_hold, cpu_run, periph_run}, 32'h4);
    pulse(1'b0);
    wait_mode(3'h0);
    chk("sub_exit", {29'h0, port_hold, cpu_run, periph_run}, 32'h3);
    end_sim();
  end
endmodule : cpm_power_ctrl_tb
